//--- hw/dac_ctl_params.svh
`ifndef DAC_CTL_PARAMS_SVH
`define DAC_CTL_PARAMS_SVH
// Register byte addresses; printed offsets 0x00 and 0x01 are indices, word address = 4 * index.
`define CONV_CTRL_IDX    8'h00
`define CONV_CODE_IDX    8'h01
`define CONV_CTRL_ADDR   12'h000
`define CONV_CODE_ADDR   12'h004
`define SLEEP_CTRL_ADDR  12'h008
`define CONV_STATE_ADDR  12'h00C
// Field positions inside the control register.
`define CTRL_ENABLE_BIT  0
`define CTRL_PINBUF_BIT  6
`define CTRL_RUNSTBY_BIT 7
// Reset values.
`define CONV_CTRL_RST    8'h00
`define CONV_CODE_RST    8'h00
// Sleep request encoding in the sleep control register.
`define SLEEP_NONE       2'h0
`define SLEEP_STANDBY    2'h1
`define SLEEP_PWRDOWN    2'h2
// Bus transfer type code for a non-sequential transfer.
`define HTRANS_NONSEQ    2'h2
`endif

//--- hw/dac_ctl_pkg.sv
package dac_ctl_pkg;
   // Power state of the converter path as seen by the sleep logic.
   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_STANDBY_RUN,
      PWR_STANDBY_OFF,
      PWR_DOWN
   } pwr_state_e;
   // Byte-wide register word.
   typedef logic [7:0] byte_t;
endpackage : dac_ctl_pkg

//--- hw/dac_control_logic.sv
`timescale 1ns/10ps
`include "dac_ctl_params.svh"

// Overview of operation
// R1 - Control bit 0 switches converter on/off.
// R2 - Enabled: each code write launches conversion.
// R3 - Disabled: code stored; enabling launches conversion.
// R4 - Control bit 6 enables pin buffer.
// R5 - Internal output available whenever converter enabled.
// R6 - Standby: run only if bit 7 set.
// R7 - Stopped standby powers down; wake restores both.
// R8 - Power-down sleep always disables converter and buffer.
// R9 - Code register is 8-bit read/write.
// R10 - Debug halt leaves converter untouched.
// R11 - Software configures, writes code, then enables.
// R12 - Analog code updates edge after launch, holds.
module dac_control_logic
   import dac_ctl_pkg::*;
(
   input  wire logic        MCLK,        // Peripheral clock, 125 MHz.
   input  wire logic        RST_B,       // Asynchronous reset, active low.
   input  wire logic        HSEL,        // Slave select.
   input  wire logic [11:0] HADDR,       // Byte address.
   input  wire logic [1:0]  HTRANS,      // Transfer type.
   input  wire logic        HWRITE,      // Write when high.
   input  wire logic [2:0]  HSIZE,       // Transfer size.
   input  wire logic [31:0] HWDATA,      // Write data.
   input  wire logic        HREADY,      // Bus ready in.
   input  wire logic        DEBUG_HALT,  // CPU halted by debugger.
   input  wire logic        CLK_PER_ON,  // Peripheral clock kept in standby.
   output logic [31:0]      HRDATA,      // Read data.
   output logic             HREADYOUT,   // Slave ready.
   output logic             HRESP,       // Always OKAY.
   output logic [7:0]       CONV_CODE,   // Code driven to the resistor string.
   output logic             CONV_POWER,  // Converter powered.
   output logic             CONV_LAUNCH, // One-cycle launch strobe.
   output logic             PIN_DRIVE,   // Pin output buffer on.
   output logic             INT_ROUTE    // Output offered to comparator and ADC.
);

   // Address-phase capture for the data phase.
   logic        wr_pend_r;               // A write data phase is running.
   logic [11:0] addr_r;                  // Captured address.
   // Software visible state.
   byte_t       ctrl_r;                  // Control register.
   byte_t       code_r;                  // Stored conversion code.
   logic [1:0]  sleep_r;                 // Requested sleep mode.
   pwr_state_e  pwr_r;                   // Current power state.
   pwr_state_e  pwr_nxt;                 // Next power state.

   // Decode of the address phase; only whole-word writes are accepted, reads of any size.
   wire addr_ok   = HSEL && HREADY && (HTRANS == `HTRANS_NONSEQ);
   wire wr_start  = addr_ok && HWRITE;
   wire rd_start  = addr_ok && !HWRITE;
   wire wr_ctrl   = wr_pend_r && (addr_r == `CONV_CTRL_ADDR);
   wire wr_code   = wr_pend_r && (addr_r == `CONV_CODE_ADDR);
   wire wr_sleep  = wr_pend_r && (addr_r == `SLEEP_CTRL_ADDR);
   wire [7:0] wdat = HWDATA[7:0];

   // Control bits; debug halt is deliberately not an input to any of them. R10
   wire en_now    = ctrl_r[`CTRL_ENABLE_BIT];
   wire en_new    = wdat[`CTRL_ENABLE_BIT];
   // Enable edge launches the stored code; a code write launches when enabled. R3
   wire launch_en = wr_ctrl && en_new && !en_now; // R3
   wire launch_wr = wr_code && en_now;            // R2
   wire launch    = launch_en || launch_wr;
   // Code used by a launch; a code write takes the freshly written value.
   wire [7:0] launch_code = wr_code ? wdat : code_r;

   // Reserved control bits read as zero.
   wire [7:0] ctrl_mask = 8'hC1;

   // Read mux for the data phase; unmapped addresses read as zero.
   wire [31:0] rd_mux =
      (HADDR == `CONV_CTRL_ADDR)  ? {24'h000000, ctrl_r} :
      (HADDR == `CONV_CODE_ADDR)  ? {24'h000000, code_r} :
      (HADDR == `SLEEP_CTRL_ADDR) ? {30'h00000000, sleep_r} :
      (HADDR == `CONV_STATE_ADDR) ? {28'h0000000, PIN_DRIVE, INT_ROUTE, pwr_r} :
      32'h00000000;

   // A write landing at this edge already steers the power outputs, so the
   // converter follows a new sleep request or control value without a lag.
   wire [1:0] sleep_eff = wr_sleep ? HWDATA[1:0] : sleep_r;
   wire       ctrl_rs   = wr_ctrl ? wdat[`CTRL_RUNSTBY_BIT] : ctrl_r[`CTRL_RUNSTBY_BIT];

   // Power state follows the sleep request; standby keeps running only with bit 7 set and the peripheral clock on. R6
   always_comb begin
      pwr_nxt = PWR_ACTIVE;
      unique case (sleep_eff)
         `SLEEP_STANDBY: begin
            if (ctrl_rs && CLK_PER_ON) begin
               pwr_nxt = PWR_STANDBY_RUN; // R6
            end else begin
               pwr_nxt = PWR_STANDBY_OFF; // R7
            end
         end
         `SLEEP_PWRDOWN: begin
            pwr_nxt = PWR_DOWN;           // R8
         end
         default: begin
            pwr_nxt = PWR_ACTIVE;
         end
      endcase
   end

   // Powered whenever enabled and not in a stopped sleep state. R7
   wire run_ok  = (pwr_nxt == PWR_ACTIVE) || (pwr_nxt == PWR_STANDBY_RUN);
   wire ctrl_en = wr_ctrl ? en_new : en_now;
   wire ctrl_ob = wr_ctrl ? wdat[`CTRL_PINBUF_BIT] : ctrl_r[`CTRL_PINBUF_BIT];

   // Bus phase tracking; every access completes without wait states.
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 12'h000;
         HRDATA    <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         wr_pend_r <= wr_start && (HSIZE == 3'h2);
         addr_r    <= HADDR;
         // Read data is registered so it stands during the data phase.
         HRDATA    <= rd_start ? rd_mux : 32'h00000000;
      end
   end

   // Register file writes; the data register is full 8-bit read/write. R9
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_r  <= `CONV_CTRL_RST;
         code_r  <= `CONV_CODE_RST;
         sleep_r <= `SLEEP_NONE;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= wdat & ctrl_mask;    // R1
         end
         if (wr_code) begin
            code_r <= wdat;                // R9
         end
         if (wr_sleep) begin
            sleep_r <= HWDATA[1:0];
         end
      end
   end

   // Output stage; the analog code changes only on a launch and holds after. R12
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         pwr_r       <= PWR_ACTIVE;
         CONV_CODE   <= `CONV_CODE_RST;
         CONV_POWER  <= 1'b0;
         CONV_LAUNCH <= 1'b0;
         PIN_DRIVE   <= 1'b0;
         INT_ROUTE   <= 1'b0;
      end else begin
         pwr_r       <= pwr_nxt;
         CONV_LAUNCH <= launch;
         if (launch) begin
            CONV_CODE <= launch_code;              // R12
         end
         CONV_POWER  <= ctrl_en && run_ok;         // R1
         PIN_DRIVE   <= ctrl_en && ctrl_ob && run_ok; // R4
         INT_ROUTE   <= ctrl_en && run_ok;         // R5
      end
   end

   // A launching write shows the new code on the next edge.
   sequence code_write_s;
      wr_code && en_now;
   endsequence

   launch_code_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R2
      code_write_s |=> (CONV_LAUNCH && CONV_CODE == $past(wdat)))
      else $error("Code write while enabled did not launch.");

   store_only_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R3
      (wr_code && !en_now && !wr_ctrl) |=> (!CONV_LAUNCH && code_r == $past(wdat)))
      else $error("Code write while disabled launched or was lost.");

   enable_launch_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R3
      (wr_ctrl && en_new && !en_now) |=> (CONV_LAUNCH && CONV_CODE == $past(code_r)))
      else $error("Enabling did not launch stored code.");

   enable_bit_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R1
      (wr_ctrl && sleep_r == `SLEEP_NONE && !wr_sleep) |=> (CONV_POWER == $past(en_new)))
      else $error("Converter power does not follow enable bit.");

   pin_buffer_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R4
      PIN_DRIVE |-> (CONV_POWER && ctrl_r[`CTRL_PINBUF_BIT]))
      else $error("Pin buffer on without enable and buffer bit.");

   internal_route_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R5
      INT_ROUTE == CONV_POWER)
      else $error("Internal route differs from converter power.");

   standby_stop_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R7
      (sleep_r == `SLEEP_STANDBY && !ctrl_r[`CTRL_RUNSTBY_BIT] && !wr_pend_r)
      |=> (!CONV_POWER && !PIN_DRIVE))
      else $error("Stopped standby left converter powered.");

   powerdown_off_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R8
      (sleep_r == `SLEEP_PWRDOWN && !wr_sleep) |=> (!CONV_POWER && !PIN_DRIVE))
      else $error("Power-down left converter powered.");

   code_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R12
      !CONV_LAUNCH |-> $stable(CONV_CODE))
      else $error("Converter code changed without a launch.");

   debug_blind_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R10
      (!wr_pend_r && !wr_sleep) ##1 (!wr_pend_r && $stable(sleep_r)) |-> $stable(ctrl_r))
      else $error("Control changed without a bus write.");

   // Standby with the keep-running bit and a live clock leaves the path on.
   // Bus writes are excluded because they may change either input this cycle.
   standby_run_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R6
      (sleep_r == `SLEEP_STANDBY && ctrl_r[`CTRL_RUNSTBY_BIT] && CLK_PER_ON && en_now
       && !wr_pend_r) |=> (CONV_POWER && INT_ROUTE))
      else $error("Standby with keep-running bit stopped the converter.");

   // Leaving standby by a sleep write while enabled.
   sequence standby_exit_s;
      sleep_r == `SLEEP_STANDBY && wr_sleep && HWDATA[1:0] == `SLEEP_NONE && en_now;
   endsequence

   // Waking from standby restores power, and the pin buffer only when its bit is set.
   // No start-up delay is modelled, so the restore is seen on the very next edge.
   standby_wake_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R7
      standby_exit_s |=> (CONV_POWER && PIN_DRIVE == $past(ctrl_r[`CTRL_PINBUF_BIT])))
      else $error("Leaving standby did not restore converter and buffer.");

   // A stopped standby shows up as the stopped state in the status word.
   // Software may poll this to know the buffer has really been switched off.
   standby_state_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R7
      (sleep_r == `SLEEP_STANDBY && !ctrl_r[`CTRL_RUNSTBY_BIT] && !wr_pend_r)
      |=> (pwr_r == PWR_STANDBY_OFF))
      else $error("Stopped standby not reported in power state.");

   // Power-down is reported as such, whatever the keep-running bit says.
   // The state word and the sleep control register read-back both show this sleep level.
   pwrdown_state_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R8
      (sleep_r == `SLEEP_PWRDOWN && !wr_sleep) |=> (pwr_r == PWR_DOWN))
      else $error("Power-down not reported in power state.");

   // Internal use needs only the enable bit; the pin buffer may stay off.
   // This is the common case when the output feeds the comparator alone.
   internal_only_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R5
      (en_now && !ctrl_r[`CTRL_PINBUF_BIT] && sleep_r == `SLEEP_NONE && !wr_pend_r)
      |=> (INT_ROUTE && !PIN_DRIVE))
      else $error("Internal route needs the pin buffer.");

   // The internal route is never offered while the enable bit is clear.
   // Both come from the same forwarded value, so they change together.
   route_enable_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R5
      INT_ROUTE |-> ctrl_r[`CTRL_ENABLE_BIT])
      else $error("Internal route offered while disabled.");

   // Every launch strobe is caused by a bus write in the cycle before.
   // A spurious strobe would restart a conversion the software never asked for.
   launch_cause_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R2
      CONV_LAUNCH |-> $past(wr_pend_r))
      else $error("Launch strobe without a bus write.");

   // While disabled, only writing the enable bit can start a conversion.
   // A code write alone is stored and waits for the enable edge.
   no_launch_off_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R3
      (!en_now && !wr_ctrl) |=> !CONV_LAUNCH)
      else $error("Launch while disabled without enabling.");

   // Rewriting the control register while enabled does not relaunch.
   // Only the rising edge of enable counts, so buffer changes stay glitch free.
   rewrite_enable_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R1
      (wr_ctrl && en_now) |=> !CONV_LAUNCH)
      else $error("Control rewrite while enabled launched.");

   // Clearing the enable bit switches the whole output path off.
   // The buffer and internal route follow power on the same edge.
   disable_off_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R1
      (wr_ctrl && !en_new) |=> (!CONV_POWER && !PIN_DRIVE && !INT_ROUTE))
      else $error("Disabling left the converter path on.");

   // A read of the code register returns the stored code, upper bits zero.
   // The read data is captured in the address phase and stands one cycle.
   code_read_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R9
      (rd_start && HADDR == `CONV_CODE_ADDR) |=> (HRDATA == {24'h000000, $past(code_r)}))
      else $error("Code register read back wrong.");

   // A read of the control register returns it, reserved bits as zero.
   // Software may thus rely on a read-modify-write leaving reserved bits clear.
   ctrl_read_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R1
      (rd_start && HADDR == `CONV_CTRL_ADDR)
      |=> (HRDATA == {24'h000000, $past(ctrl_r)} && HRDATA[5:1] == 5'h00))
      else $error("Control register read back wrong.");

   // Reads beyond the last register return zero.
   // This keeps a stray pointer from seeing stale data from another register.
   unmapped_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      (rd_start && HADDR > `CONV_STATE_ADDR) |=> (HRDATA == 32'h00000000))
      else $error("Unmapped read returned data.");

   // A write of other than a whole word is ignored.
   // Narrow writes would otherwise land in the wrong byte lane.
   size_ignored_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      (wr_start && HSIZE != 3'h2) |=> !wr_pend_r)
      else $error("Narrow write was accepted.");

   // The slave never stalls and always answers OKAY.
   // The master therefore never sees a wait state from this block.
   bus_okay_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      HREADYOUT && !HRESP)
      else $error("Bus response not ready and OKAY.");

   // A change of debug halt with no bus write leaves registers and code alone.
   // Halting the processor must not disturb a converter already running.
   debug_still_a: assert property (@(posedge MCLK) disable iff (!RST_B) // R10
      (!wr_pend_r && $changed(DEBUG_HALT))
      |=> ($stable(CONV_CODE) && $stable(ctrl_r) && $stable(code_r)))
      else $error("Debug halt changed converter state.");

endmodule : dac_control_logic

//--- bench/test_dac_control_logic.sv
`timescale 1ns/10ps
`include "dac_ctl_params.svh"

module test_dac_control_logic;
   logic        MCLK, RST_B, HSEL, HWRITE, DEBUG_HALT, CLK_PER_ON;
   logic [11:0] HADDR;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE;
   logic [31:0] HWDATA, HRDATA;
   logic        HREADYOUT, HRESP, CONV_POWER, CONV_LAUNCH, PIN_DRIVE, INT_ROUTE;
   logic [7:0]  CONV_CODE;
   wire         HREADY = HREADYOUT; // The one slave's ready is the bus ready.
   int          n_mismatch = 0;     // Counted mismatches.
   int          comparisons = 0;    // Counted comparisons.
   integer      seed = 17893;       // Fixed seed keeps runs repeatable.
   logic [7:0]  ctrl_m, code_m, cc_m; // Model of control, code and launched code.
   logic [1:0]  sl_m;               // Model of the sleep request.
   logic [31:0] rd;                 // Last read data.

   dac_control_logic dut (.MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
      .DEBUG_HALT(DEBUG_HALT), .CLK_PER_ON(CLK_PER_ON), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CONV_CODE(CONV_CODE), .CONV_POWER(CONV_POWER),
      .CONV_LAUNCH(CONV_LAUNCH), .PIN_DRIVE(PIN_DRIVE), .INT_ROUTE(INT_ROUTE));

   // Free-running 125 MHz clock.
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end

   // Debug halt toggles at random; the converter must not notice it.
   always @(posedge MCLK) begin
      DEBUG_HALT <= $random(seed);
   end

   task report_and_stop;
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   task cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // One single AHB-Lite transfer; each wait ends when HREADYOUT is high, else at the watchdog.
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
      @(posedge MCLK);
      HSEL <= 1'b1; HTRANS <= `HTRANS_NONSEQ; HADDR <= a; HWRITE <= w; HSIZE <= sz;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : bus

   // Compares outputs with the model; lch 2 means the strobe is not judged.
   task chk(input int lch);
      logic pw;
      pw = ctrl_m[0] & ~((sl_m == 2'h1 && !(ctrl_m[7] && CLK_PER_ON)) || sl_m == 2'h2);
      cmp({CONV_LAUNCH, CONV_POWER, PIN_DRIVE, INT_ROUTE},
          {(lch == 2) ? CONV_LAUNCH : lch[0], pw, pw & ctrl_m[6], pw});
      cmp(CONV_CODE, cc_m);
   endtask : chk

   // Write a register, step the model, then look at the launch cycle.
   task wr(input logic [11:0] a, input logic [7:0] d);
      int lch;
      lch = (a == `SLEEP_CTRL_ADDR) ? 2 : 0;
      bus(1'b1, a, {$random(seed)} << 8 | d, 3'h2);
      if (a == `CONV_CTRL_ADDR) begin
         if (!ctrl_m[0] && d[0]) begin lch = 1; cc_m = code_m; end
         ctrl_m = d & 8'hC1;
      end
      if (a == `CONV_CODE_ADDR) begin
         code_m = d;
         if (ctrl_m[0]) begin lch = 1; cc_m = d; end
      end
      if (a == `SLEEP_CTRL_ADDR) sl_m = d[1:0];
      #1 chk(lch);
   endtask : wr

   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 3'h2);
      cmp(rd, exp);
      cmp({31'h0, HRESP}, 32'h0);
   endtask : rdchk

   // Watchdog sized well beyond the 134 or so cycles the tests need.
   initial begin
      #160000;
      n_mismatch++;
      report_and_stop;
   end

   initial begin
      RST_B = 1'b0; HSEL = 1'b0; HADDR = 12'h000; HTRANS = 2'h0; HWRITE = 1'b0;
      HSIZE = 3'h2; HWDATA = 32'h0; DEBUG_HALT = 1'b0; CLK_PER_ON = 1'b0;
      ctrl_m = 8'h00; code_m = 8'h00; cc_m = 8'h00; sl_m = 2'h0;
      repeat (4) @(posedge MCLK);
      RST_B <= 1'b1;
      rdchk(`CONV_CTRL_ADDR, 32'h0);
      rdchk(`CONV_CODE_ADDR, 32'h0);
      rdchk(12'h010, 32'h0);
      wr(`CONV_CODE_ADDR, 8'h5A);
      rdchk(`CONV_CODE_ADDR, 32'h5A);
      wr(`CONV_CTRL_ADDR, 8'h01);
      wr(`CONV_CTRL_ADDR, 8'h01);
      repeat (6) wr(`CONV_CODE_ADDR, 8'($random(seed)));
      bus(1'b1, `CONV_CODE_ADDR, 32'hA5, 3'h0);
      rdchk(`CONV_CODE_ADDR, {24'h0, code_m});
      wr(`CONV_CTRL_ADDR, 8'h41);
      wr(`CONV_CTRL_ADDR, 8'h01);
      wr(`CONV_CTRL_ADDR, 8'h00);
      wr(`CONV_CODE_ADDR, 8'hC3);
      wr(`CONV_CTRL_ADDR, 8'h41);
      // Every pairing of run-in-standby and clock availability.
      for (int k = 0; k < 4; k++) begin
         wr(`CONV_CTRL_ADDR, k[1] ? 8'hC1 : 8'h41);
         @(posedge MCLK) CLK_PER_ON <= k[0];
         wr(`SLEEP_CTRL_ADDR, `SLEEP_STANDBY);
         rdchk(`CONV_STATE_ADDR, (k == 3) ? 32'hD : 32'h2);
         wr(`SLEEP_CTRL_ADDR, `SLEEP_NONE);
      end
      wr(`SLEEP_CTRL_ADDR, `SLEEP_PWRDOWN);
      rdchk(`CONV_STATE_ADDR, 32'h3);
      rdchk(`SLEEP_CTRL_ADDR, 32'h2);
      wr(`SLEEP_CTRL_ADDR, `SLEEP_NONE);
      wr(`CONV_CTRL_ADDR, 8'hFF);
      rdchk(`CONV_CTRL_ADDR, 32'hC1);
      report_and_stop;
   end
endmodule : test_dac_control_logic
